// [rtl/xoc_pkg.sv]
// package: register map, field layout, reset values and modes of the clock config bank
package xoc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses (word aligned)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_OSC = 4'h0;
  localparam logic [3:0] ADDR_DIV = 4'h4;
  localparam logic [3:0] ADDR_DRV_EN = 4'h8;
  localparam logic [3:0] ADDR_DRV_MODE = 4'hc;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OSC_SPARE_LSB = 17;
  localparam int OSC_REG_BIT = 16;
  localparam int OSC_GAIN_LSB = 14;
  localparam int OSC_XOUT_LSB = 8;
  localparam int OSC_RSV_LSB = 6;
  localparam int OSC_XIN_LSB = 0;
  localparam int DIV_REG_BIT = 15;
  localparam int DIV_RATIO_LSB = 0;
  localparam int EN_DIS_LSB = 2;
  localparam int EN_OFF_BIT = 1;
  localparam int EN_PD_BIT = 0;
  localparam int MODE_CMOS_LSB = 6;
  localparam int MODE_CM_LSB = 4;
  localparam int MODE_TERM_BIT = 3;
  localparam int MODE_BIAS_BIT = 2;
  localparam int MODE_TYPE_LSB = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_OSC = 32'h0001_5f1f;
  localparam logic [15:0] RST_DIV = 16'h8069;
  localparam logic [7:0] RST_DRV_EN = 8'h00;
  localparam logic [7:0] RST_DRV_MODE = 8'h6c;

  // writable bits of each register; all others read zero
  localparam logic [31:0] MASK_OSC = 32'h0007_ffff;
  localparam logic [15:0] MASK_DIV = 16'hbfff;
  localparam logic [7:0] MASK_DRV_EN = 8'h0f;
  localparam logic [7:0] MASK_DRV_MODE = 8'hff;

  // trim codes above this are reserved
  localparam logic [5:0] TRIM_MAX = 6'h2f;
  // smallest legal divide ratio
  localparam logic [13:0] DIV_MIN = 14'h000a;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  localparam logic [1:0] TYPE_HCSL = 2'h0;
  localparam logic [1:0] TYPE_LVDS = 2'h2;
  localparam logic [1:0] TYPE_CMOS = 2'h3;
  localparam logic [1:0] DIS_LOW_LOW = 2'h0;
  localparam logic [1:0] DIS_LOW_HIGH = 2'h1;
  localparam logic [1:0] DIS_HIZ = 2'h2;
  localparam logic [1:0] DIS_RUN = 2'h3;
  localparam logic [1:0] CMOS_SAME = 2'h0;
  localparam logic [1:0] CMOS_OPP = 2'h1;
  localparam logic [1:0] CMOS_TRUE = 2'h2;
  localparam logic [1:0] CMOS_COMP = 2'h3;

  // analogue control points of the oscillator and divider
  typedef struct packed {
    logic osc_regulator_on;
    logic [1:0] boost_count;
    logic [5:0] xout_trim;
    logic [5:0] xin_trim;
    logic [1:0] osc_spare_bits;
    logic divider_regulator_on;
    logic [13:0] divide_ratio;
    logic divide_ratio_bad;
  } xoc_core_ctrl_t;

  // controls and pin state of the output driver
  typedef struct packed {
    logic driver_power_down;
    logic driver_enabled;
    logic bias_on;
    logic hcsl_term_on;
    logic [1:0] lvds_common_level;
    logic [1:0] driver_type;
    logic true_oe;
    logic true_val;
    logic comp_oe;
    logic comp_val;
    logic true_runs;
    logic comp_runs;
    logic comp_inverted;
  } xoc_drv_ctrl_t;

endpackage

// [rtl/xoc_pin_mux.sv]
// module: output pin pair decoder for the clock driver
`timescale 1ns/1ns
module xoc_pin_mux (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] driver_type_in,
  input wire logic [1:0] cmos_phase_in,
  input wire logic [1:0] dis_state_in,
  input wire logic force_off_in,
  input wire logic power_down_in,
  input wire logic oe_pin_in,
  output logic driver_enabled_out,
  output logic true_oe_out,
  output logic true_val_out,
  output logic comp_oe_out,
  output logic comp_val_out,
  output logic true_runs_out,
  output logic comp_runs_out,
  output logic comp_inverted_out
);

  // ----------------------------------------------------------------
  // output enable pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] oe_sync;
  logic oe_level;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      oe_sync <= 3'h7;
    end else begin
      oe_sync <= {oe_sync[1:0], oe_pin_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      oe_level <= 1'b1;
    end else if (oe_sync[1] == oe_sync[2]) begin
      oe_level <= oe_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // pin decode, registered
  // ----------------------------------------------------------------
  logic next_en, next_toe, next_tv, next_coe, next_cv, next_tr, next_cr, next_ci;

  always_comb begin
    // power down ignores every enable control and tri-states the pair
    next_en = !power_down_in && !force_off_in && oe_level; // [R08] [R09]
    next_toe = 1'b0;
    next_tv = 1'b0;
    next_coe = 1'b0;
    next_cv = 1'b0;
    next_tr = 1'b0;
    next_cr = 1'b0;
    next_ci = 1'b0;
    if (power_down_in) begin
      next_toe = 1'b0; // [R09]
      next_coe = 1'b0;
    end else if (next_en || dis_state_in == xoc_pkg::DIS_RUN) begin
      // running; debug state keeps toggling while disabled [R07]
      next_toe = 1'b1;
      next_coe = 1'b1;
      next_tr = 1'b1;
      next_cr = 1'b1;
      next_ci = 1'b1;
      if (driver_type_in == xoc_pkg::TYPE_CMOS) begin
        case (cmos_phase_in) // [R10]
          xoc_pkg::CMOS_SAME: next_ci = 1'b0;
          xoc_pkg::CMOS_OPP: next_ci = 1'b1;
          xoc_pkg::CMOS_TRUE: next_cr = 1'b0;
          xoc_pkg::CMOS_COMP: next_tr = 1'b0;
          default: next_ci = 1'b1;
        endcase
      end
    end else begin
      case (dis_state_in) // [R07]
        xoc_pkg::DIS_LOW_LOW: begin
          next_toe = 1'b1;
          next_coe = 1'b1;
          next_cv = (driver_type_in == xoc_pkg::TYPE_LVDS);
        end
        xoc_pkg::DIS_LOW_HIGH: begin
          next_toe = 1'b1;
          next_coe = 1'b1;
          next_cv = 1'b1;
        end
        xoc_pkg::DIS_HIZ: begin
          next_toe = 1'b0;
          next_coe = 1'b0;
        end
        default: begin
          next_toe = 1'b1;
          next_coe = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      driver_enabled_out <= 1'b0;
      true_oe_out <= 1'b0;
      true_val_out <= 1'b0;
      comp_oe_out <= 1'b0;
      comp_val_out <= 1'b0;
      true_runs_out <= 1'b0;
      comp_runs_out <= 1'b0;
      comp_inverted_out <= 1'b0;
    end else begin
      driver_enabled_out <= next_en;
      true_oe_out <= next_toe;
      true_val_out <= next_tv;
      comp_oe_out <= next_coe;
      comp_val_out <= next_cv;
      true_runs_out <= next_tr;
      comp_runs_out <= next_cr;
      comp_inverted_out <= next_ci;
    end
  end

endmodule

// [rtl/xoc_config_bank.sv]
// module: avalon register bank for oscillator, output divider and output driver settings
//
// How it works
// R01: oscillator regulator on while bit 16 is one; resets to one.
// R02: bits 15:14 choose zero to three startup boost amplifiers; resets to one.
// R03: output pin trim adds 0.5 pF per code up to 0x2f; resets 0x1f.
// R04: input pin trim at bits 5:0 behaves the same; 0x30 up reserved.
// R05: divider register bit 15 turns the divider regulator on; resets to one.
// R06: software programs divide ratio ten or more; field resets to 0x69.
// R07: disabled-state field sets pin pair: low/low (low/high for lvds), low/high, hi-z, or toggling.
// R08: force-off bit disables the driver; clear leaves other controls in charge.
// R09: power-down tri-states both pins and overrides every enable control.
// R10: cmos phase: same, opposite, true pin only, complement pin only.
// R11: lvds common level code picks 700 to 1000 mV; resets to 900 mV.
// R12: mode bit 3 connects internal 50 ohm hcsl termination when one.
// R13: mode bit 2 enables driver bias; resets to one.
// R14: driver type: hcsl 0, lvds 2, cmos 3, code 1 reserved; resets 0.
// R15: reserved read-only bits read zero and ignore writes; the oscillator reserved bits 7:6 are writable and read back.
`timescale 1ns/1ns
module xoc_config_bank (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic oe_pin_in,
  output xoc_pkg::xoc_core_ctrl_t core_ctrl_out,
  output xoc_pkg::xoc_drv_ctrl_t drv_ctrl_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // merge write data under byte enables and the writable mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~(lanes & mask)) | (wd & lanes & mask);
  endfunction

  // true when a trim code lands in the reserved range
  function automatic logic trim_bad(input logic [5:0] code);
    trim_bad = code > xoc_pkg::TRIM_MAX;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] crystal_osc_config;
  logic [15:0] output_divider_config;
  logic [7:0] output_driver_enable_ctrl;
  logic [7:0] output_driver_mode_config;
  logic busy;
  logic hit;
  logic access;

  assign access = avs_read || avs_write;
  assign hit = (avs_address == xoc_pkg::ADDR_OSC) || (avs_address == xoc_pkg::ADDR_DIV) ||
               (avs_address == xoc_pkg::ADDR_DRV_EN) || (avs_address == xoc_pkg::ADDR_DRV_MODE);

  // one wait cycle per access: the answer comes on the second edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy <= 1'b0;
    end else begin
      busy <= access && !busy;
    end
  end

  assign avs_waitrequest = access && !busy;

  // oscillator register; masking keeps bits 31:19 at zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      crystal_osc_config <= xoc_pkg::RST_OSC; // [R01] [R02] [R03] [R04]
    end else if (avs_write && busy && avs_address == xoc_pkg::ADDR_OSC) begin
      crystal_osc_config <= merge(crystal_osc_config, avs_writedata, avs_byteenable,
                                  xoc_pkg::MASK_OSC); // [R15]
    end
  end

  // divider register; bit 14 never stores
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      output_divider_config <= xoc_pkg::RST_DIV; // [R05] [R06]
    end else if (avs_write && busy && avs_address == xoc_pkg::ADDR_DIV) begin
      output_divider_config <= 16'(merge({16'h0000, output_divider_config}, avs_writedata,
                                         avs_byteenable, {16'h0000, xoc_pkg::MASK_DIV})); // [R15]
    end
  end

  // driver enable register; upper nibble stays zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      output_driver_enable_ctrl <= xoc_pkg::RST_DRV_EN;
    end else if (avs_write && busy && avs_address == xoc_pkg::ADDR_DRV_EN) begin
      output_driver_enable_ctrl <= 8'(merge({24'h000000, output_driver_enable_ctrl},
                                            avs_writedata, avs_byteenable,
                                            {24'h000000, xoc_pkg::MASK_DRV_EN})); // [R15]
    end
  end

  // driver mode register, fully writable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      output_driver_mode_config <= xoc_pkg::RST_DRV_MODE; // [R11] [R13] [R14]
    end else if (avs_write && busy && avs_address == xoc_pkg::ADDR_DRV_MODE) begin
      output_driver_mode_config <= 8'(merge({24'h000000, output_driver_mode_config},
                                            avs_writedata, avs_byteenable,
                                            {24'h000000, xoc_pkg::MASK_DRV_MODE}));
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // status word at the driver enable address: bits 7:4 read zero, so live
  // state is shown only through the core and driver control outputs
  logic [31:0] next_rdata;

  always_comb begin
    case (avs_address)
      xoc_pkg::ADDR_OSC: next_rdata = crystal_osc_config;
      xoc_pkg::ADDR_DIV: next_rdata = {16'h0000, output_divider_config};
      xoc_pkg::ADDR_DRV_EN: next_rdata = {24'h000000, output_driver_enable_ctrl};
      xoc_pkg::ADDR_DRV_MODE: next_rdata = {24'h000000, output_driver_mode_config};
      default: next_rdata = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // read data and response are registered on the wait cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'h0;
    end else if (access && !busy) begin
      avs_readdata <= avs_read ? next_rdata : 32'h0000_0000;
      avs_response <= hit ? 2'h0 : 2'h3; // decode error on unmapped
    end
  end

  // ----------------------------------------------------------------
  // oscillator and divider controls
  // ----------------------------------------------------------------
  logic [13:0] ratio;
  assign ratio = output_divider_config[xoc_pkg::DIV_RATIO_LSB +: 14];

  // reserved trim codes are clamped to the top legal step before the analogue side
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      core_ctrl_out <= '0;
    end else begin
      core_ctrl_out.osc_regulator_on <= crystal_osc_config[xoc_pkg::OSC_REG_BIT]; // [R01]
      core_ctrl_out.boost_count <= crystal_osc_config[xoc_pkg::OSC_GAIN_LSB +: 2]; // [R02]
      core_ctrl_out.xout_trim <= trim_bad(crystal_osc_config[xoc_pkg::OSC_XOUT_LSB +: 6]) ?
                                 xoc_pkg::TRIM_MAX :
                                 crystal_osc_config[xoc_pkg::OSC_XOUT_LSB +: 6]; // [R03]
      core_ctrl_out.xin_trim <= trim_bad(crystal_osc_config[xoc_pkg::OSC_XIN_LSB +: 6]) ?
                                xoc_pkg::TRIM_MAX :
                                crystal_osc_config[xoc_pkg::OSC_XIN_LSB +: 6]; // [R04]
      core_ctrl_out.osc_spare_bits <= crystal_osc_config[xoc_pkg::OSC_SPARE_LSB +: 2];
      core_ctrl_out.divider_regulator_on <= output_divider_config[xoc_pkg::DIV_REG_BIT]; // [R05]
      core_ctrl_out.divide_ratio <= ratio;
      core_ctrl_out.divide_ratio_bad <= ratio < xoc_pkg::DIV_MIN; // [R06]
    end
  end

  // ----------------------------------------------------------------
  // output driver
  // ----------------------------------------------------------------
  logic drv_en, t_oe, t_v, c_oe, c_v, t_r, c_r, c_i;

  xoc_pin_mux u_pin_mux (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .driver_type_in(output_driver_mode_config[xoc_pkg::MODE_TYPE_LSB +: 2]),
    .cmos_phase_in(output_driver_mode_config[xoc_pkg::MODE_CMOS_LSB +: 2]),
    .dis_state_in(output_driver_enable_ctrl[xoc_pkg::EN_DIS_LSB +: 2]),
    .force_off_in(output_driver_enable_ctrl[xoc_pkg::EN_OFF_BIT]),
    .power_down_in(output_driver_enable_ctrl[xoc_pkg::EN_PD_BIT]),
    .oe_pin_in(oe_pin_in),
    .driver_enabled_out(drv_en),
    .true_oe_out(t_oe),
    .true_val_out(t_v),
    .comp_oe_out(c_oe),
    .comp_val_out(c_v),
    .true_runs_out(t_r),
    .comp_runs_out(c_r),
    .comp_inverted_out(c_i)
  );

  // power-down and mode fields to the analogue driver, held in their own flops
  logic drv_pd, drv_bias, drv_term;
  logic [1:0] drv_cm, drv_type;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drv_pd <= 1'b0;
      drv_bias <= 1'b0;
      drv_term <= 1'b0;
      drv_cm <= 2'h0;
      drv_type <= 2'h0;
    end else begin
      drv_pd <= output_driver_enable_ctrl[xoc_pkg::EN_PD_BIT]; // [R09]
      drv_bias <= output_driver_mode_config[xoc_pkg::MODE_BIAS_BIT]; // [R13]
      drv_term <= output_driver_mode_config[xoc_pkg::MODE_TERM_BIT]; // [R12]
      drv_cm <= output_driver_mode_config[xoc_pkg::MODE_CM_LSB +: 2]; // [R11]
      drv_type <= output_driver_mode_config[xoc_pkg::MODE_TYPE_LSB +: 2]; // [R14]
    end
  end

  // one continuous driver for the whole struct keeps every bit to a single source;
  // pin state is already registered inside the pin decoder
  assign drv_ctrl_out = {drv_pd, drv_en, drv_bias, drv_term, drv_cm, drv_type, // [R08]
                         t_oe, t_v, c_oe, c_v, t_r, c_r, c_i};

endmodule

// [test/xoc_config_bank_chk.sv]
// checker: bus timing and field relations of the clock config bank
`timescale 1ns/1ns
module xoc_config_bank_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic oe_pin_in,
  input wire xoc_pkg::xoc_core_ctrl_t core_ctrl_out,
  input wire xoc_pkg::xoc_drv_ctrl_t drv_ctrl_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // completed accesses
  // ----------------------------------------------------------------
  sequence s_wr(logic [3:0] a);
    avs_write && !avs_waitrequest && avs_address == a;
  endsequence
  sequence s_rd(logic [3:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // exactly one wait cycle per request
  AST_ONE_WAIT:
    assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_OSC_REG:
    assert property (s_wr(xoc_pkg::ADDR_OSC) ##0 avs_byteenable[2] |->
      ##2 core_ctrl_out.osc_regulator_on == $past(avs_writedata[16], 2))
    else $error("oscillator regulator control does not follow write");
  AST_OSC_GAIN:
    assert property (s_wr(xoc_pkg::ADDR_OSC) ##0 avs_byteenable[1] |->
      ##2 core_ctrl_out.boost_count == $past(avs_writedata[15:14], 2))
    else $error("boost count does not follow write");
  AST_DIV_REG:
    assert property (s_wr(xoc_pkg::ADDR_DIV) ##0 avs_byteenable[1] |->
      ##2 core_ctrl_out.divider_regulator_on == $past(avs_writedata[15], 2))
    else $error("divider regulator control does not follow write");
  // first edge after release still shows zeros, so skip it
  AST_DIV_BAD:
    assert property (!$past(rst_in) |->
      core_ctrl_out.divide_ratio_bad == (core_ctrl_out.divide_ratio < 14'h000a))
    else $error("low divide ratio flag wrong");
  // pin fields update on the same edge as the power-down field
  AST_PD_PINS:
    assert property (drv_ctrl_out.driver_power_down ##1 drv_ctrl_out.driver_power_down |->
      !(drv_ctrl_out.true_oe || drv_ctrl_out.comp_oe || drv_ctrl_out.driver_enabled))
    else $error("powered down driver still drives a pin");
  AST_FORCE_OFF:
    assert property (s_wr(xoc_pkg::ADDR_DRV_EN) ##0 avs_byteenable[0] && avs_writedata[1]
      |-> ##5 !drv_ctrl_out.driver_enabled)
    else $error("force-off did not disable driver");
  AST_MODE_TYPE:
    assert property (s_wr(xoc_pkg::ADDR_DRV_MODE) ##0 avs_byteenable[0] |->
      ##2 drv_ctrl_out.driver_type == $past(avs_writedata[1:0], 2))
    else $error("driver type does not follow write");
  AST_MODE_CM:
    assert property (s_wr(xoc_pkg::ADDR_DRV_MODE) ##0 avs_byteenable[0] |->
      ##2 drv_ctrl_out.lvds_common_level == $past(avs_writedata[5:4], 2))
    else $error("common level does not follow write");
  AST_MODE_BITS:
    assert property (s_wr(xoc_pkg::ADDR_DRV_MODE) ##0 avs_byteenable[0] |->
      ##2 {drv_ctrl_out.hcsl_term_on, drv_ctrl_out.bias_on} == $past(avs_writedata[3:2], 2))
    else $error("termination or bias does not follow write");
  AST_RSV_DIV:
    assert property (s_rd(xoc_pkg::ADDR_DIV) |-> (avs_readdata & 32'hffff_4000) == 32'h0)
    else $error("reserved divider bits read nonzero");
  AST_UNMAPPED:
    assert property (s_rd(4'h6) |-> avs_response == 2'h3 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind xoc_config_bank xoc_config_bank_chk xoc_config_bank_chk_i (
  .clk_in(clk_in), .rst_in(rst_in), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .oe_pin_in(oe_pin_in), .core_ctrl_out(core_ctrl_out),
  .drv_ctrl_out(drv_ctrl_out)
);

// [test/tb.sv]
// testbench: register access and output pin decode of the clock config bank
`timescale 1ns/1ns
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic oe_pin_in = 1'b1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  xoc_pkg::xoc_core_ctrl_t c;
  xoc_pkg::xoc_drv_ctrl_t d;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  // en, mode, oe pin, expected {enabled, runs t/c, oe t, val t, oe c, val c, inverted}
  typedef struct packed {logic [7:0] en; logic [7:0] mode; logic oe; logic [7:0] exp;} xoc_row_t;
  xoc_row_t rows [14];

  xoc_config_bank xoc_config_bank_i (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .oe_pin_in(oe_pin_in), .core_ctrl_out(c), .drv_ctrl_out(d)
  );

  // 125 MHz clock
  initial begin
    forever #4 clk_in = ~clk_in;
  end

  // hang guard: whole run needs well under this
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // one avalon access; held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v,
                     input logic [3:0] be);
    @(posedge clk_in);
    avs_address <= a;
    avs_writedata <= v;
    avs_byteenable <= be;
    avs_read <= ~w;
    avs_write <= w;
    @(posedge clk_in);
    while (avs_waitrequest !== 1'b0) @(posedge clk_in);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // write, then let the control outputs settle before anyone looks
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] be);
    bus(1'b1, a, v, be);
    repeat (3) @(negedge clk_in);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rd, want);
  endtask

  // running pins have no static level, so their value bit is masked
  function automatic logic [31:0] pins();
    return {24'h0, d.driver_enabled, d.true_runs, d.comp_runs, d.true_oe,
            d.true_val & ~d.true_runs, d.comp_oe, d.comp_val & ~d.comp_runs,
            d.comp_inverted & d.true_runs & d.comp_runs};
  endfunction

  // oscillator fields by name: spare, regulator, boost, output trim, input trim
  function automatic logic [31:0] osc_bits();
    return {15'h0, c.osc_spare_bits, c.osc_regulator_on, c.boost_count, c.xout_trim,
            c.xin_trim};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{8'h00, 8'h2f, 1'b1, 8'hf4};
    rows[1] = '{8'h00, 8'h6f, 1'b1, 8'hf5};
    rows[2] = '{8'h00, 8'haf, 1'b1, 8'hd4};
    rows[3] = '{8'h00, 8'hef, 1'b1, 8'hb4};
    rows[4] = '{8'h00, 8'h6c, 1'b1, 8'hf5};
    rows[5] = '{8'h00, 8'h6e, 1'b1, 8'hf5};
    rows[6] = '{8'h02, 8'h6c, 1'b1, 8'h14};
    rows[7] = '{8'h02, 8'h6e, 1'b1, 8'h16};
    rows[8] = '{8'h06, 8'h6c, 1'b1, 8'h16};
    rows[9] = '{8'h0a, 8'h6c, 1'b1, 8'h00};
    rows[10] = '{8'h0e, 8'h2f, 1'b1, 8'h74};
    rows[11] = '{8'h04, 8'h6c, 1'b0, 8'h16};
    rows[12] = '{8'h01, 8'h6c, 1'b1, 8'h00};
    rows[13] = '{8'h0d, 8'h2f, 1'b0, 8'h00};
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      wr(xoc_pkg::ADDR_DRV_EN, {24'h0, rows[i].en}, 4'hf);
      wr(xoc_pkg::ADDR_DRV_MODE, {24'h0, rows[i].mode}, 4'hf);
      @(posedge clk_in);
      oe_pin_in <= rows[i].oe;
      repeat (8) @(negedge clk_in);
      check(pins(), {24'h0, rows[i].exp});
      check({31'h0, d.driver_power_down}, {31'h0, rows[i].en[0]});
      rdc(xoc_pkg::ADDR_DRV_EN, {24'h0, rows[i].en});
    end
    // second reset in mid-run, then reset values
    @(posedge clk_in);
    oe_pin_in <= 1'b1;
    rst_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(xoc_pkg::ADDR_OSC, 32'h0001_5f1f);
    rdc(xoc_pkg::ADDR_DIV, 32'h0000_8069);
    rdc(xoc_pkg::ADDR_DRV_EN, 32'h0);
    rdc(xoc_pkg::ADDR_DRV_MODE, 32'h0000_006c);
    check(osc_bits(), {15'h0, 2'h0, 1'b1, 2'h1, 6'h1f, 6'h1f});
    check({28'h0, d.bias_on, d.hcsl_term_on, d.lvds_common_level}, 32'he);
    // reserved bits and trim ceiling
    wr(xoc_pkg::ADDR_OSC, 32'hffff_ffff, 4'hf);
    rdc(xoc_pkg::ADDR_OSC, 32'h0007_ffff);
    check(osc_bits(),
          {15'h0, 2'h3, 1'b1, 2'h3, xoc_pkg::TRIM_MAX, xoc_pkg::TRIM_MAX});
    wr(xoc_pkg::ADDR_OSC, 32'h0, 4'hf);
    wr(xoc_pkg::ADDR_OSC, 32'hffff_ffff, 4'h4);
    rdc(xoc_pkg::ADDR_OSC, 32'h0007_0000);
    check(osc_bits(), {15'h0, 2'h3, 1'b1, 2'h0, 6'h0, 6'h0});
    wr(xoc_pkg::ADDR_DIV, 32'hffff_ffff, 4'hf);
    rdc(xoc_pkg::ADDR_DIV, 32'h0000_bfff);
    check({16'h0, c[15:0]}, {16'h0, 1'b1, 14'h3fff, 1'b0});
    wr(xoc_pkg::ADDR_DIV, 32'h0000_0009, 4'hf);
    check({16'h0, c[15:0]}, {16'h0, 1'b0, 14'h0009, 1'b1});
    wr(xoc_pkg::ADDR_DIV, 32'h0000_000a, 4'hf);
    check({16'h0, c[15:0]}, {16'h0, 1'b0, 14'h000a, 1'b0});
    // every code of type, common level and phase, both term and bias values
    for (int m = 0; m < 16; m++) begin
      wr(xoc_pkg::ADDR_DRV_MODE, {24'h0, m[3:0], m[3:0]}, 4'hf);
      check({26'h0, d.bias_on, d.hcsl_term_on, d.lvds_common_level, d.driver_type},
            {26'h0, m[2], m[3], m[1:0], m[1:0]});
      rdc(xoc_pkg::ADDR_DRV_MODE, {24'h0, m[3:0], m[3:0]});
    end
    // unmapped place: write ignored, read refused
    bus(1'b1, 4'h6, 32'hffff_ffff, 4'hf);
    bus(1'b0, 4'h6, 32'h0, 4'hf);
    check(rd, 32'h0);
    check({30'h0, rsp}, 32'h3);
    rdc(xoc_pkg::ADDR_OSC, 32'h0007_0000);
    check({30'h0, rsp}, 32'h0);
    conclude();
  end
endmodule
